/* File: tic_pkg.sv */
// package for the two-channel timer interrupt and count control block
// assumes an ahb-lite register bus with 32-bit words and one clock
package tic_pkg;
  localparam int TIC_NCH = 2;
  localparam int TIC_NSRC = 6;
  // register byte offsets
  localparam logic [7:0] TIC_OFS_START = 8'h00;
  localparam logic [7:0] TIC_OFS_CTRL0 = 8'h10;
  localparam logic [7:0] TIC_OFS_CNT0 = 8'h14;
  localparam logic [7:0] TIC_OFS_PER0 = 8'h18;
  localparam logic [7:0] TIC_OFS_STAT0 = 8'h1C;
  localparam logic [7:0] TIC_OFS_IEN0 = 8'h20;
  localparam logic [7:0] TIC_OFS_ICTL0 = 8'h24;
  localparam logic [7:0] TIC_OFS_CMPB0 = 8'h28;
  localparam logic [7:0] TIC_CH_STRIDE = 8'h20;
  localparam logic [7:0] TIC_OFS_IRQST = 8'h50;
  localparam logic [7:0] TIC_OFS_IRQMSK = 8'h54;
  // start/stop register: start bits [1:0], stop-select bits [5:4]
  localparam int TIC_START_LSB = 0;
  localparam int TIC_SEL_LSB = 4;
  // control register fields
  localparam int TIC_CCLR_LSB = 0;
  localparam int TIC_TCK_LSB = 4;
  localparam int TIC_POUT_BIT = 8;
  // interrupt control: priority [2:0], request flag [3]
  localparam int TIC_IR_BIT = 3;
  // status bits: 0 cmp a, 1 cmp b, 4 overflow, 5 reads as one
  localparam int TIC_ST_CMPA = 0;
  localparam int TIC_ST_CMPB = 1;
  localparam int TIC_ST_OVF = 4;
  localparam int TIC_ST_FIXED = 5;
  localparam logic [2:0] TIC_CCLR_PER = 3'h1;
  localparam logic [2:0] TIC_CCLR_CMPB = 3'h2;
  localparam logic [2:0] TIC_CCLR_SYNC = 3'h3;
  localparam logic [2:0] TIC_CCLR_CMPC = 3'h5;
  localparam logic [2:0] TIC_CCLR_CMPD = 3'h6;
  localparam logic [2:0] TIC_TCK_FOSC = 3'h6;
  localparam logic [15:0] TIC_CNT_ZERO = 16'h0000;
  localparam logic [15:0] TIC_CNT_ONE = 16'h0001;
  localparam logic [15:0] TIC_CNT_MAX = 16'hFFFF;
  localparam logic [1:0] TIC_HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] TIC_HSIZE_WORD = 3'h2;
  typedef enum logic [1:0] {TIC_ST_IDLE = 2'b00, TIC_ST_ACC = 2'b01} tic_bus_t;
endpackage : tic_pkg

/* File: tic_timer_irq_ctrl.sv */
// How it works
// - each channel gathers four sources (six status bits) into one request flag and priority field.
// - request flag is one while any enabled status flag is one.
// - request flag falls once no enabled status flag remains; nothing latched.
// - request stays high while another enabled source still stands.
// - acknowledge leaves status flags alone; software clears them.
// - status flag clears only on writing zero after reading it as one.
// - status register shows which enabled source raised the request.
// - acceptance uses global flag, request, priority level and processor level.
// - with stop-select zero, writing start zero is ignored.
// - with stop-select zero, period match clears start bit, and clears counter only under clear source code 1.
// - software stop needs stop-select one first, start zero in a later write.
// - software stop holds each output pin at its prior level.
// - period-match stop holds the level set by that match.
// - hardware clear beats a coinciding counter write; counter becomes zero.
// - clear source codes 1 period, 2 cmp b, 3 sync, 5 cmp c, 6 cmp d.
// - a read right after a write may return the old value.
// - count source code six selects the fast on-chip oscillator.
// file holds the complete block as an ahb-lite slave; count enables arrive as pins
// assumes count source ticks and fast oscillator tick are pulses from other clock logic
`timescale 1ns/1ps
`default_nettype none
module tic_timer_irq_ctrl #(
  parameter int CW = 16
) (
  input wire logic hclk, // 250 mhz clock
  input wire logic hresetn, // async reset, active low
  input wire logic hsel, // slave select
  input wire logic [31:0] haddr, // byte address
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write when high
  input wire logic [2:0] hsize, // transfer size
  input wire logic [31:0] hwdata, // write data
  input wire logic hready, // bus ready
  output logic [31:0] hrdata, // read data
  output logic hreadyout, // slave ready
  output logic hresp, // always okay
  input wire logic [6:0] src_tick, // count source ticks by select code, pins
  input wire logic [1:0] ext_src_b, // extra status sources c,d per channel pin
  input wire logic sync_clr, // synchronous clear request pin
  input wire logic glob_ie, // global interrupt enable flag
  input wire logic [2:0] processor_priority_level, // current processor level
  input wire logic [1:0] irq_ack, // acknowledge pulse per channel
  output logic [1:0] irq_req, // accepted request per channel
  output logic [1:0] pwm_out, // timer output pin per channel
  output logic irq // summary interrupt level
);
  import tic_pkg::*;

  // pin vector layout: count sources 0..6, extra sources 7..8, sync clear 9
  localparam int PIN_EXT = 7;
  localparam int PIN_SYNC = 9;
  localparam int PIN_W = 10;

  // two-flop synchronisers on outside pins
  logic [PIN_W-1:0] pin_s1_r, pin_s2_r;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_s1_r <= '0;
      pin_s2_r <= '0;
    end else begin
      pin_s1_r <= {sync_clr, ext_src_b, src_tick};
      pin_s2_r <= pin_s1_r;
    end
  end
  logic [PIN_W-1:0] pin_d_r;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) pin_d_r <= '0;
    else pin_d_r <= pin_s2_r;
  end
  logic [PIN_W-1:0] pin_rise;
  assign pin_rise = pin_s2_r & ~pin_d_r;

  function automatic logic [7:0] ch_ofs(input logic [7:0] base, input int ch);
    ch_ofs = base + (ch[0] ? TIC_CH_STRIDE : 8'h00);
  endfunction : ch_ofs

  // bus address phase capture
  logic wr_pend_r, rd_pend_r;
  logic [7:0] a_r;
  logic acc;
  assign acc = hsel && hready && htrans == TIC_HTRANS_NONSEQ;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
      a_r <= '0;
    end else begin
      wr_pend_r <= acc && hwrite;
      rd_pend_r <= acc && !hwrite;
      a_r <= haddr[7:0];
    end
  end
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  logic [1:0] start_r, sel_r;
  logic [8:0] ctrl_r [TIC_NCH];
  logic [CW-1:0] cnt_r [TIC_NCH];
  logic [CW-1:0] per_r [TIC_NCH];
  logic [CW-1:0] cmpb_r [TIC_NCH];
  logic [TIC_NSRC-1:0] stat_r [TIC_NCH];
  logic [TIC_NSRC-1:0] seen_r [TIC_NCH];
  logic [TIC_NSRC-1:0] ien_r [TIC_NCH];
  logic [2:0] lvl_r [TIC_NCH];
  logic [1:0] ir_st_r, ir_msk_r;
  logic [1:0] pout_r;
  logic [1:0] ir_flag;

  logic wr_start;
  assign wr_start = wr_pend_r && a_r == TIC_OFS_START;

  for (genvar c = 0; c < TIC_NCH; c++) begin : g_ch
    logic [2:0] cclr, tck;
    logic tick, per_m, b_m, clr_hw, ovf, wr_cnt;
    logic [TIC_NSRC-1:0] ev;
    assign cclr = ctrl_r[c][TIC_CCLR_LSB +: 3];
    assign tck = ctrl_r[c][TIC_TCK_LSB +: 3];
    // source select, code six is fast oscillator
    assign tick = start_r[c] && (tck <= TIC_TCK_FOSC) && pin_rise[tck];
    assign per_m = tick && cnt_r[c] == per_r[c];
    assign b_m = tick && cnt_r[c] == cmpb_r[c];
    assign ovf = tick && cnt_r[c] == TIC_CNT_MAX && !per_m;
    always_comb begin
      case (cclr)
        TIC_CCLR_PER: clr_hw = per_m;
        TIC_CCLR_CMPB: clr_hw = b_m;
        TIC_CCLR_SYNC: clr_hw = pin_rise[PIN_SYNC];
        TIC_CCLR_CMPC, TIC_CCLR_CMPD: clr_hw = tick && pin_rise[PIN_EXT + c];
        default: clr_hw = 1'b0;
      endcase
    end
    assign wr_cnt = wr_pend_r && a_r == ch_ofs(TIC_OFS_CNT0, c);
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) cnt_r[c] <= CW'(TIC_CNT_ZERO);
      else if (clr_hw) cnt_r[c] <= CW'(TIC_CNT_ZERO);
      else if (wr_cnt) cnt_r[c] <= hwdata[CW-1:0];
      else if (tick) cnt_r[c] <= cnt_r[c] + CW'(TIC_CNT_ONE);
    end
    // pin changes on matches, or on a control write while stopped; no matches occur at stop
    // period match sets inactive level; it stays when stop-select is zero and the channel stops
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) pout_r[c] <= 1'b0;
      else if (per_m) pout_r[c] <= 1'b0;
      else if (b_m) pout_r[c] <= 1'b1;
      else if (wr_pend_r && a_r == ch_ofs(TIC_OFS_CTRL0, c) && !start_r[c])
        pout_r[c] <= hwdata[TIC_POUT_BIT];
    end
    assign ev = {1'b0, ovf, pin_rise[PIN_EXT + c], 1'b0, b_m, per_m};
    // clear needs a prior read of one; ack does not touch it
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        stat_r[c] <= '0;
        seen_r[c] <= '0;
      end else begin
        if (rd_pend_r && a_r == ch_ofs(TIC_OFS_STAT0, c)) seen_r[c] <= stat_r[c];
        if (wr_pend_r && a_r == ch_ofs(TIC_OFS_STAT0, c)) begin
          stat_r[c] <= ev | (stat_r[c] & ~(seen_r[c] & ~hwdata[TIC_NSRC-1:0]));
          seen_r[c] <= '0;
        end else begin
          stat_r[c] <= stat_r[c] | ev;
        end
      end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        ien_r[c] <= '0;
        lvl_r[c] <= '0;
        ctrl_r[c] <= '0;
        per_r[c] <= TIC_CNT_MAX;
        cmpb_r[c] <= TIC_CNT_MAX;
      end else if (wr_pend_r) begin
        if (a_r == ch_ofs(TIC_OFS_IEN0, c)) ien_r[c] <= hwdata[TIC_NSRC-1:0];
        if (a_r == ch_ofs(TIC_OFS_ICTL0, c)) lvl_r[c] <= hwdata[2:0];
        if (a_r == ch_ofs(TIC_OFS_CTRL0, c)) ctrl_r[c] <= hwdata[8:0];
        if (a_r == ch_ofs(TIC_OFS_PER0, c)) per_r[c] <= hwdata[CW-1:0];
        if (a_r == ch_ofs(TIC_OFS_CMPB0, c)) cmpb_r[c] <= hwdata[CW-1:0];
      end
    end
    assign ir_flag[c] = |(stat_r[c] & ien_r[c]);
    // acceptance by global flag and priority compare
    assign irq_req[c] = glob_ie && ir_flag[c] && lvl_r[c] > processor_priority_level;

    // an enabled event raises the request on the next cycle
    AST_IR_LEVEL: assert property (@(posedge hclk) disable iff (!hresetn)
      !wr_pend_r && |(ev & ien_r[c]) |=> ir_flag[c]) else $error("request flag missing");
    AST_ACK_KEEP: assert property (@(posedge hclk) disable iff (!hresetn)
      irq_ack[c] && !wr_pend_r |=> (stat_r[c] & $past(stat_r[c])) == $past(stat_r[c]))
      else $error("ack changed status");
    AST_CLR_WIN: assert property (@(posedge hclk) disable iff (!hresetn)
      clr_hw && wr_cnt |=> cnt_r[c] == TIC_CNT_ZERO) else $error("write beat clear");
    AST_PER_HOLD: assert property (@(posedge hclk) disable iff (!hresetn)
      per_m && !sel_r[c] && !(wr_start && hwdata[TIC_START_LSB + c])
      |=> !start_r[c] && !pout_r[c]) else $error("no self stop");
    AST_W1_NOEFF: assert property (@(posedge hclk) disable iff (!hresetn)
      wr_pend_r && a_r == ch_ofs(TIC_OFS_STAT0, c) && (&hwdata[TIC_NSRC-1:0])
      |=> (stat_r[c] & $past(stat_r[c])) == $past(stat_r[c])) else $error("w1 cleared");
    AST_STOP_PIN: assert property (@(posedge hclk) disable iff (!hresetn)
      !start_r[c] && !wr_pend_r |=> $stable(pout_r[c])) else $error("pin moved at stop");
  end

  // start zero obeyed only under a stop-select already one
  // period match stop when stop-select zero
  // source change relies on a stopped channel
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      start_r <= '0;
      sel_r <= '0;
    end else begin
      for (int c = 0; c < TIC_NCH; c++) begin
        if (wr_start && hwdata[TIC_START_LSB + c]) start_r[c] <= 1'b1;
        else if (wr_start && sel_r[c]) start_r[c] <= 1'b0;
        else if (!sel_r[c] && g_ch[0].per_m && c == 0) start_r[c] <= 1'b0;
        else if (!sel_r[c] && g_ch[1].per_m && c == 1) start_r[c] <= 1'b0;
        if (wr_start) sel_r[c] <= hwdata[TIC_SEL_LSB + c];
      end
    end
  end
  AST_SEL0_IGN: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_start && !sel_r[0] && start_r[0] && !g_ch[0].per_m |=> start_r[0])
    else $error("start zero not ignored");
  // a write carrying stop-select one and start zero must not stop the count
  AST_SAME_WR: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_start && hwdata[TIC_SEL_LSB] && !hwdata[TIC_START_LSB] && !sel_r[0] && start_r[0]
    && !g_ch[0].per_m |=> start_r[0])
    else $error("one-write stop");
  // second write of a software stop
  sequence s_sw_stop;
    sel_r[0] && start_r[0] && wr_start && !hwdata[TIC_START_LSB];
  endsequence
  AST_SW_STOP: assert property (@(posedge hclk) disable iff (!hresetn)
    s_sw_stop |=> !start_r[0]) else $error("software stop ignored");

  // summary interrupt: sticky per channel on request rise, write one clears
  logic [1:0] ir_d_r;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) ir_d_r <= '0;
    else ir_d_r <= ir_flag;
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ir_st_r <= '0;
      ir_msk_r <= '0;
    end else begin
      // set wins over the write-one clear
      if (wr_pend_r && a_r == TIC_OFS_IRQST)
        ir_st_r <= (ir_st_r & ~hwdata[1:0]) | (ir_flag & ~ir_d_r);
      else ir_st_r <= ir_st_r | (ir_flag & ~ir_d_r);
      if (wr_pend_r && a_r == TIC_OFS_IRQMSK) ir_msk_r <= hwdata[1:0];
    end
  end
  assign irq = |(ir_st_r & ir_msk_r);
  assign pwm_out = pout_r;

  // status read shows sources; reads see registers one cycle late
  // wait before oscillator stop is software's, nothing held here
  always_comb begin
    hrdata = '0;
    case (a_r)
      TIC_OFS_START: hrdata = {26'h0, sel_r, 2'h0, start_r};
      TIC_OFS_IRQST: hrdata = {30'h0, ir_st_r};
      TIC_OFS_IRQMSK: hrdata = {30'h0, ir_msk_r};
      default: begin
        for (int c = 0; c < TIC_NCH; c++) begin
          if (a_r == ch_ofs(TIC_OFS_CTRL0, c)) hrdata = {23'h0, ctrl_r[c]};
          if (a_r == ch_ofs(TIC_OFS_CNT0, c)) hrdata = {16'h0, cnt_r[c]};
          if (a_r == ch_ofs(TIC_OFS_PER0, c)) hrdata = {16'h0, per_r[c]};
          if (a_r == ch_ofs(TIC_OFS_CMPB0, c)) hrdata = {16'h0, cmpb_r[c]};
          if (a_r == ch_ofs(TIC_OFS_IEN0, c)) hrdata = {26'h0, ien_r[c]};
          if (a_r == ch_ofs(TIC_OFS_ICTL0, c))
            hrdata = {28'h0, ir_flag[c], lvl_r[c]};
          if (a_r == ch_ofs(TIC_OFS_STAT0, c))
            hrdata = {26'h0, stat_r[c] | (TIC_NSRC'(1) << TIC_ST_FIXED)};
        end
      end
    endcase
  end
endmodule : tic_timer_irq_ctrl
`default_nettype wire

/* File: tic_far_model.sv */
// far-side model: count source tick pins and the interrupt controller acknowledge
// assumes the same clock as the block; ticks are level pins, edges count
`timescale 1ns/1ps
`default_nettype none
module tic_far_model (
  input wire logic hclk, // clock
  input wire logic hresetn, // reset, active low
  input wire logic slow, // slow tick rate when high
  input wire logic fast_oscillator_enable, // fast source runs when high
  input wire logic [1:0] irq_req, // accepted requests
  output logic [6:0] src_tick, // count source levels
  output logic [1:0] irq_ack // acknowledge pulses
);
  logic [3:0] div_r;
  logic [1:0] req_r;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_r <= 4'h0;
      src_tick <= 7'h00;
    end else begin
      div_r <= div_r + 4'h1;
      src_tick[5:0] <= {6{slow ? div_r[3] : div_r[1]}};
      // fast source ticks every second cycle so its selection is visible
      src_tick[6] <= fast_oscillator_enable && div_r[0];
    end
  end
  // acknowledge only
  // the acknowledge never touches status, the handler must clear flags itself
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      req_r <= 2'h0;
      irq_ack <= 2'h0;
    end else begin
      req_r <= irq_req;
      irq_ack <= irq_req & ~req_r;
    end
  end
endmodule : tic_far_model
`default_nettype wire

/* File: tb.sv */
// testbench for the timer interrupt and count control block
// assumes the far-side model supplies ticks and acknowledges requests
`timescale 1ns/1ps
`default_nettype none
module tb;
  import tic_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic [6:0] src_tick;
  logic sync_clr = 1'b0;
  logic fast_oscillator_enable = 1'b1;
  logic [1:0] ext_src_b = 2'h0;
  logic glob_ie = 1'b0;
  logic [2:0] ppl = 3'h0;
  logic [1:0] irq_ack;
  logic [1:0] irq_req;
  logic [1:0] pwm_out;
  logic irq;
  logic slow = 1'b0;
  int num_errors = 0;
  int num_checks = 0;
  int cycles = 0;
  int seed = 19;
  int i;
  logic [31:0] q;
  logic [31:0] v;
  logic [31:0] lr;
  logic [31:0] st;
  logic [2:0] codes [5] = '{TIC_CCLR_PER, TIC_CCLR_CMPB, TIC_CCLR_SYNC, TIC_CCLR_CMPC, TIC_CCLR_CMPD};
  always #2 hclk = ~hclk;
  tic_timer_irq_ctrl #(.CW(16)) tic_timer_irq_ctrl_inst (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .src_tick(src_tick), .ext_src_b(ext_src_b), .sync_clr(sync_clr),
    .glob_ie(glob_ie), .processor_priority_level(ppl), .irq_ack(irq_ack),
    .irq_req(irq_req), .pwm_out(pwm_out), .irq(irq));
  tic_far_model tic_far_model_inst (.hclk(hclk), .hresetn(hresetn), .slow(slow),
    .fast_oscillator_enable(fast_oscillator_enable),
    .irq_req(irq_req), .src_tick(src_tick), .irq_ack(irq_ack));
  // a zero written clears only what the last read showed as one
  function automatic logic [31:0] exp_stat(logic [31:0] cur, logic [31:0] rd, logic [31:0] w);
    return ((cur & ~(rd & ~w)) | 32'h20) & 32'h3F;
  endfunction : exp_stat
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= TIC_HTRANS_NONSEQ;
    hwrite <= wr;
    hsize <= TIC_HSIZE_WORD;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    q = hrdata;
  endtask : bus
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      num_errors++;
    end
  endtask : chk
  task automatic rc(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(q, exp);
  endtask : rc
  task automatic conclude;
    $display("checks=%0d errors=%0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : conclude
  always @(posedge hclk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      conclude();
    end
  end
  initial begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    rc(TIC_OFS_STAT0, 32'h20);
    rc(TIC_OFS_IRQST, 32'h0);
    rc(8'h7C, 32'h0);
    for (i = 0; i < 5; i++) begin
      bus(1'b1, TIC_OFS_CTRL0, {29'h0, codes[i]});
      rc(TIC_OFS_CTRL0, {29'h0, codes[i]});
    end
    for (i = 0; i < 4; i++) begin
      v = $random(seed) & 32'hFFFF;
      bus(1'b1, TIC_OFS_CNT0, v);
      rc(TIC_OFS_CNT0, v);
    end
    bus(1'b1, TIC_OFS_CTRL0, {29'h0, TIC_CCLR_PER});
    bus(1'b1, TIC_OFS_PER0, 32'h5);
    bus(1'b1, TIC_OFS_CMPB0, 32'h2);
    bus(1'b1, TIC_OFS_CNT0, 32'h0);
    bus(1'b1, TIC_OFS_START, 32'h01);
    q = 32'h1;
    for (i = 0; i < 100 && q[0] !== 1'b0; i++) bus(1'b0, TIC_OFS_START, 32'h0);
    chk(q, 32'h0);
    rc(TIC_OFS_CNT0, 32'h0);
    chk({31'h0, pwm_out[0]}, 32'h0);
    rc(TIC_OFS_STAT0, 32'h23);
    lr = q;
    slow <= 1'b1;
    bus(1'b1, TIC_OFS_PER0, 32'hFFF);
    bus(1'b1, TIC_OFS_START, 32'h01);
    repeat (200) @(posedge hclk);
    bus(1'b1, TIC_OFS_START, 32'h00);
    rc(TIC_OFS_START, 32'h01);
    bus(1'b1, TIC_OFS_START, 32'h10);
    rc(TIC_OFS_START, 32'h11);
    bus(1'b1, TIC_OFS_START, 32'h10);
    rc(TIC_OFS_START, 32'h10);
    chk({31'h0, pwm_out[0]}, 32'h1);
    bus(1'b0, TIC_OFS_CNT0, 32'h0);
    v = q;
    repeat (60) @(posedge hclk);
    rc(TIC_OFS_CNT0, v);
    chk({31'h0, pwm_out[0]}, 32'h1);
    bus(1'b1, TIC_OFS_IEN0, 32'h09);
    bus(1'b1, TIC_OFS_ICTL0, 32'h5);
    bus(1'b1, TIC_OFS_IRQMSK, 32'h1);
    glob_ie <= 1'b1;
    ppl <= 3'h2;
    repeat (4) @(posedge hclk);
    chk({30'h0, irq_req}, 32'h1);
    rc(TIC_OFS_ICTL0, 32'h0D);
    ppl <= 3'h5;
    repeat (2) @(posedge hclk);
    chk({30'h0, irq_req}, 32'h0);
    ppl <= 3'h2;
    glob_ie <= 1'b0;
    repeat (2) @(posedge hclk);
    chk({30'h0, irq_req}, 32'h0);
    glob_ie <= 1'b1;
    rc(TIC_OFS_STAT0, 32'h23);
    st = q;
    ext_src_b[0] <= 1'b1;
    repeat (6) @(posedge hclk);
    bus(1'b1, TIC_OFS_STAT0, 32'h0);
    st = exp_stat(st | 32'h8, st, 32'h0);
    rc(TIC_OFS_STAT0, st);
    rc(TIC_OFS_ICTL0, 32'h0D);
    bus(1'b1, TIC_OFS_STAT0, 32'hFF);
    rc(TIC_OFS_STAT0, st);
    bus(1'b1, TIC_OFS_STAT0, 32'h0);
    rc(TIC_OFS_STAT0, exp_stat(st, st, 32'h0));
    rc(TIC_OFS_ICTL0, 32'h05);
    chk({30'h0, irq_req}, 32'h0);
    chk({31'h0, irq}, 32'h1);
    bus(1'b1, TIC_OFS_IRQMSK, 32'h0);
    @(posedge hclk);
    chk({31'h0, irq}, 32'h0);
    bus(1'b1, TIC_OFS_IRQMSK, 32'h1);
    bus(1'b1, TIC_OFS_IRQST, 32'h1);
    @(posedge hclk);
    chk({31'h0, irq}, 32'h0);
    rc(TIC_OFS_IRQST, 32'h0);
    // fast source counts every second cycle, the others far slower
    bus(1'b1, TIC_OFS_CTRL0, {25'h0, TIC_TCK_FOSC, 1'b0, TIC_CCLR_SYNC});
    bus(1'b1, TIC_OFS_CNT0, 32'h0);
    bus(1'b1, TIC_OFS_START, 32'h11);
    repeat (40) @(posedge hclk);
    bus(1'b1, TIC_OFS_START, 32'h10);
    rc(TIC_OFS_START, 32'h10);
    bus(1'b0, TIC_OFS_CNT0, 32'h0);
    chk({31'h0, q > 32'h8}, 32'h1);
    bus(1'b1, TIC_OFS_CTRL0, {29'h0, TIC_CCLR_SYNC});
    repeat (2) @(posedge hclk);
    fast_oscillator_enable <= 1'b0;
    // the synchronised clear edge lands on the write's data phase
    @(posedge hclk);
    sync_clr <= 1'b1;
    bus(1'b1, TIC_OFS_CNT0, 32'h1234);
    sync_clr <= 1'b0;
    rc(TIC_OFS_CNT0, 32'h0);
    conclude();
  end
endmodule : tb
`default_nettype wire
